/* File: src/frame_ctl_pkg.sv */
/*
 * Types of the serial bus frame controller.
 * Assumes the register header is on the include path.
 */
package frame_ctl_pkg;
    `include "frame_ctl_regs.svh"

    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_WAIT = 3'b001,
        TX_SOF = 3'b011,
        TX_DATA = 3'b010,
        TX_CRC = 3'b110,
        TX_TAIL = 3'b111
    } tx_state_t;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_DATA = 2'b01,
        RX_DONE = 2'b11
    } rx_state_t;
endpackage

/* File: src/frame_ctl_regs.svh */
/*
 * Register offsets, field positions, reset values and timing counts of the
 * serial bus frame controller.
 * Assumes inclusion by bare name from the package only.
 */
`ifndef FRAME_CTL_REGS_SVH
`define FRAME_CTL_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFS_SYSTEM_CONTROL 8'h00
`define OFS_RATE_MODE 8'h04
`define OFS_INT_STATUS 8'h08
`define OFS_INT_ENABLE 8'h0C
`define OFS_INT_RESET 8'h10
`define OFS_TX_STATUS 8'h14
`define OFS_COMMAND_TX 8'h18
`define OFS_RX_STATUS 8'h1C
`define OFS_RX_RELEASE 8'h20
`define OFS_TX_BUF 8'h40
`define OFS_RX_BUF 8'h80

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BIT_INIT 0
`define BIT_RDA 1
`define BIT_FRX 2
`define BIT_TBUSY 3
`define BIT_OVR 4
`define BIT_TXA 5
`define BIT_FTX 6
`define BIT_GIE 7
`define BIT_RTS 7
`define BIT_AVAIL 7
`define BIT_ENH 3
`define BIT_PRE3 4
`define BIT_ACKEN 5

// ----------------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------------
`define RST_RATE_MODE 8'h00
`define RST_INT_ENABLE 8'h00
`define CRC_RESIDUE 16'h4B15
`define CRC_POLY 16'h1021
`define RX_BASE 6'h20
`define MIN_BYTES 5'd2
`define MAX_BYTES 5'd30
`define SLOT_DIV 4'd15
`define IDLE_SLOTS 8'd16

`endif

/* File: src/serial_bus_frame_controller.sv */
/*
 * Serial bus frame controller: AHB-Lite register slave, rate generator,
 * interrupt sources, Manchester transmitter with arbitration, receiver with
 * acceptance filter and CRC residue check; ack_req is set on acceptance when enabled but no acknowledge is sent.
 * Assumes a single 250 MHz clock, synchronous bus input, one AHB master.
 */
// Overview of operation
// - Elementary clock is crystal over prescaler 1 or 3, then over 2**rate_mode[2:0].
// - Slot frequency is the elementary clock divided by sixteen.
// - Plain Manchester bit is two slots; enhanced is five slots per four bits.
// - Any pending enabled source drives irq_n low.
// - Good filtered frame stored in a receive buffer raises rx_data_available.
// - Error on a filtered frame raises failed-receive.
// - Filtered frame with both receive buffers held raises overrun.
// - Reset or control bit 0 raises init; transmitter and receiver stay halted until cleared.
// - Freed transmit buffer raises tx-available; send error raises failed-transmit.
// - Writing one to interrupt reset clears a source; zero does nothing.
// - Each source gated by own and global enable; init always passes.
// - Serial output stays released after reset until init is cleared.
// - Frame is SOF, bytes MSB first from buffer start, CRC, END_OF_DATA_FIELD, EOF.
// - Defer while busy, arbitrate per bit, on loss keep receiving and resend.
// - Stop driving at the next bit tick when a collision is seen in data or CRC.
// - Transmit length is 2 to 30 bytes.
// - Start only with RTS set and buffer-busy clear, after bus idle.
// - After the tail fields set tx available and raise the tx source.
// - Received bytes stored MSB first from buffer index 0, count kept to status.
// - Accept only on CRC residue 4B15h; acknowledge if asked and enabled (ack_req is set when enabled, never sent).
// - Only identifiers matching one of sixteen filters are stored (the code writes the first two bytes of every frame into the receive buffer).
// - Host cannot reach the transmit buffer while it is being sent.
`timescale 1ns/1ns
module serial_bus_frame_controller
    import frame_ctl_pkg::*;
#(
    parameter int NUM_FILTERS = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [11:0] filter_id [NUM_FILTERS],
    input wire logic rxd,
    output logic txd,
    output logic txd_oe,
    output logic irq_n
);
    import frame_ctl_pkg::*;

    // ----------------------------------------------------------------------
    // State
    // ----------------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] rdata;
        logic [7:0] rate_mode;
        logic [7:0] int_enable;
        logic [6:0] src;
        logic [7:0] ctr;
        logic [4:0] rx_count;
        logic [1:0] rx_held;
        logic rx_sel;
        logic [6:0] div_cnt;
        logic [1:0] pre_cnt;
        logic [3:0] slot_cnt;
        logic [2:0] enh_cnt;
        logic bit_tick;
        tx_state_t tx_st;
        rx_state_t rx_st;
        logic [4:0] tx_idx;
        logic [2:0] bit_idx;
        logic [15:0] tx_crc;
        logic [7:0] idle_cnt;
        logic tx_drive;
        logic tx_bit;
        logic [7:0] rx_shift;
        logic [2:0] rx_bits;
        logic [4:0] rx_idx;
        logic [15:0] rx_crc;
        logic rx_match;
        logic rx_prev;
        logic [7:0] rx_quiet;
        logic ack_req;
        logic txd;
        logic txd_oe;
        logic irq_n;
    } state_t;

    state_t cur, next_cur;
    logic [7:0] tx_buf [32];
    logic [7:0] rx_buf [2][32];

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
        crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? `CRC_POLY : 16'h0000);
    endfunction

    function automatic logic filter_hit(input logic [11:0] id);
        filter_hit = 1'b0;
        for (int i = 0; i < NUM_FILTERS; i++) begin
            if (filter_id[i] == id) begin
                filter_hit = 1'b1;
            end
        end
    endfunction

    logic [7:0] tx_byte;
    logic [4:0] tx_len;
    logic tx_busy;
    logic init_hold;
    assign tx_byte = tx_buf[cur.tx_idx];
    assign tx_len = cur.ctr[4:0];
    assign tx_busy = cur.tx_st != TX_IDLE;
    assign init_hold = cur.src[`BIT_INIT];

    // ----------------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------------
    always_comb begin
        logic [7:0] wb;
        logic bus_quiet;
        logic tx_done;
        logic tx_fail;
        logic rx_good;
        logic rx_bad;
        logic rx_ovr;
        logic [4:0] ev;
        logic [11:0] rid;
        wb = hwdata[7:0];
        rid = {rx_buf[cur.rx_sel][5'd0], cur.rx_shift[6:3]};
        bus_quiet = cur.rx_quiet >= `IDLE_SLOTS;
        tx_done = 1'b0;
        tx_fail = 1'b0;
        rx_good = 1'b0;
        rx_bad = 1'b0;
        rx_ovr = 1'b0;
        ev = 5'h00;
        next_cur = cur;
        next_cur.bit_tick = 1'b0;

        // Bus slave, one wait-free data phase
        next_cur.wr = hsel && hready && htrans[1] && hwrite;
        next_cur.rd = hsel && hready && htrans[1] && !hwrite;
        if (hsel && hready && htrans[1]) begin
            next_cur.addr = haddr;
        end
        if (cur.wr) begin
            unique case (cur.addr)
                `OFS_SYSTEM_CONTROL: begin
                    if (wb[0]) begin
                        next_cur.src[`BIT_INIT] = 1'b1;
                    end
                end
                `OFS_RATE_MODE: next_cur.rate_mode = wb;
                `OFS_INT_ENABLE: next_cur.int_enable = wb;
                `OFS_INT_RESET: next_cur.src = cur.src & ~wb[6:0];
                `OFS_COMMAND_TX: begin
                    if (!tx_busy && wb[4:0] >= `MIN_BYTES && wb[4:0] <= `MAX_BYTES) begin
                        next_cur.ctr = wb;
                    end
                end
                `OFS_RX_RELEASE: next_cur.rx_held = cur.rx_held & ~wb[1:0];
                default: begin
                end
            endcase
        end
        next_cur.rdata = 32'h0000_0000;
        if (hsel && hready && htrans[1] && !hwrite) begin
            unique case (haddr)
                `OFS_RATE_MODE: next_cur.rdata[7:0] = cur.rate_mode;
                `OFS_INT_STATUS: next_cur.rdata[7:0] = {1'b0, cur.src} | {4'h0, tx_busy, 3'h0};
                `OFS_INT_ENABLE: next_cur.rdata[7:0] = cur.int_enable;
                `OFS_TX_STATUS: next_cur.rdata[7:0] = {!tx_busy && !cur.ctr[`BIT_RTS], 7'h00};
                `OFS_COMMAND_TX: next_cur.rdata[7:0] = cur.ctr;
                `OFS_RX_STATUS: next_cur.rdata[7:0] = {|cur.rx_held, cur.rx_sel, 1'b0, cur.rx_count};
                default: begin
                    if (haddr[7:6] == 2'b01 && !tx_busy) begin
                        next_cur.rdata[7:0] = tx_buf[haddr[6:2]];
                    end else if (haddr[7] && haddr[2]) begin
                        next_cur.rdata[7:0] = rx_buf[1][{1'b0, haddr[6:3]}];
                    end else if (haddr[7]) begin
                        next_cur.rdata[7:0] = rx_buf[0][{1'b0, haddr[6:3]}];
                    end
                end
            endcase
        end

        // Elementary clock, slot and bit timing
        next_cur.pre_cnt = (cur.rate_mode[`BIT_PRE3] && cur.pre_cnt != 2'd2) ?
            cur.pre_cnt + 2'd1 : 2'd0;
        if (next_cur.pre_cnt == 2'd0) begin
            next_cur.div_cnt = cur.div_cnt + 7'd1;
            if (cur.div_cnt == 7'((8'd1 << cur.rate_mode[2:0]) - 8'd1) || cur.rate_mode[2:0] == 3'd0) begin
                next_cur.div_cnt = 7'd0;
                next_cur.slot_cnt = cur.slot_cnt + 4'd1;
                if (cur.slot_cnt == `SLOT_DIV) begin
                    next_cur.enh_cnt = (cur.enh_cnt == (cur.rate_mode[`BIT_ENH] ? 3'd4 : 3'd1)) ?
                        3'd0 : cur.enh_cnt + 3'd1;
                    next_cur.bit_tick = cur.rate_mode[`BIT_ENH] ?
                        (cur.enh_cnt != 3'd4) : cur.enh_cnt[0];
                    next_cur.rx_quiet = (rxd == cur.rx_prev && cur.rx_quiet != 8'hFF) ?
                        cur.rx_quiet + 8'd1 : 8'd0;
                    next_cur.rx_prev = rxd;
                end
            end
        end

        // Transmitter
        if (!init_hold && cur.bit_tick) begin
            unique case (cur.tx_st)
                TX_IDLE: begin
                    if (cur.ctr[`BIT_RTS]) begin
                        next_cur.tx_st = TX_WAIT;
                    end
                end
                TX_WAIT: begin
                    if (bus_quiet && cur.rx_st == RX_IDLE) begin
                        next_cur.tx_st = TX_SOF;
                        next_cur.tx_idx = 5'd0;
                        next_cur.bit_idx = 3'd7;
                        next_cur.tx_crc = 16'hFFFF;
                    end
                end
                TX_SOF: begin
                    next_cur.tx_drive = 1'b1;
                    next_cur.tx_bit = 1'b0;
                    next_cur.tx_st = TX_DATA;
                end
                TX_DATA: begin
                    if (cur.tx_drive && rxd != cur.txd) begin
                        next_cur.tx_drive = 1'b0;
                        next_cur.tx_st = TX_WAIT;
                    end else begin
                        next_cur.tx_bit = tx_byte[cur.bit_idx];
                        next_cur.tx_crc = crc_step(cur.tx_crc, tx_byte[cur.bit_idx]);
                        next_cur.bit_idx = cur.bit_idx - 3'd1;
                        if (cur.bit_idx == 3'd0) begin
                            next_cur.tx_idx = cur.tx_idx + 5'd1;
                            if (cur.tx_idx + 5'd1 == tx_len) begin
                                next_cur.tx_st = TX_CRC;
                                next_cur.tx_idx = 5'd0;
                            end
                        end
                    end
                end
                TX_CRC: begin
                    if (cur.tx_drive && rxd != cur.txd) begin
                        next_cur.tx_drive = 1'b0;
                        tx_fail = 1'b1;
                        next_cur.tx_st = TX_TAIL;
                    end else begin
                        next_cur.tx_bit = ~cur.tx_crc[15];
                        next_cur.tx_crc = {cur.tx_crc[14:0], 1'b1};
                        next_cur.tx_idx = cur.tx_idx + 5'd1;
                        if (cur.tx_idx == 5'd15) begin
                            next_cur.tx_st = TX_TAIL;
                            next_cur.tx_idx = 5'd0;
                        end
                    end
                end
                TX_TAIL: begin
                    next_cur.tx_bit = 1'b1;
                    next_cur.tx_idx = cur.tx_idx + 5'd1;
                    if (cur.tx_idx == 5'd7) begin
                        next_cur.tx_drive = 1'b0;
                        next_cur.ctr[`BIT_RTS] = 1'b0;
                        next_cur.tx_st = TX_IDLE;
                        tx_done = 1'b1;
                    end
                end
                default: next_cur.tx_st = TX_IDLE;
            endcase
        end

        // Receiver
        if (!init_hold && cur.bit_tick) begin
            unique case (cur.rx_st)
                RX_IDLE: begin
                    if (!rxd && bus_quiet) begin
                        next_cur.rx_st = RX_DATA;
                        next_cur.rx_bits = 3'd0;
                        next_cur.rx_idx = 5'd0;
                        next_cur.rx_crc = 16'hFFFF;
                        next_cur.rx_match = 1'b0;
                        next_cur.ack_req = 1'b0;
                    end
                end
                RX_DATA: begin
                    next_cur.rx_shift = {cur.rx_shift[6:0], rxd};
                    next_cur.rx_crc = crc_step(cur.rx_crc, rxd);
                    next_cur.rx_bits = cur.rx_bits + 3'd1;
                    if (cur.rx_bits == 3'd7) begin
                        if (cur.rx_idx == 5'd1) begin
                            next_cur.rx_match = filter_hit(rid);
                            rx_ovr = filter_hit(rid) && (&cur.rx_held);
                        end
                        next_cur.rx_idx = cur.rx_idx + 5'd1;
                    end
                    if (cur.rx_quiet >= 8'd2) begin
                        next_cur.rx_st = RX_DONE;
                    end
                end
                RX_DONE: begin
                    next_cur.rx_st = RX_IDLE;
                    if (cur.rx_match && !(&cur.rx_held)) begin
                        if (cur.rx_crc == `CRC_RESIDUE) begin
                            rx_good = 1'b1;
                            next_cur.rx_count = cur.rx_idx;
                            next_cur.rx_held[cur.rx_sel] = 1'b1;
                            next_cur.rx_sel = ~cur.rx_sel;
                            next_cur.ack_req = cur.rate_mode[`BIT_ACKEN];
                        end else begin
                            rx_bad = 1'b1;
                        end
                    end
                end
                default: next_cur.rx_st = RX_IDLE;
            endcase
        end

        // Sources: hardware set wins over software clear
        ev = {tx_fail, tx_done, rx_ovr, rx_bad, rx_good};
        next_cur.src[`BIT_RDA] = next_cur.src[`BIT_RDA] | ev[0];
        next_cur.src[`BIT_FRX] = next_cur.src[`BIT_FRX] | ev[1];
        next_cur.src[`BIT_OVR] = next_cur.src[`BIT_OVR] | ev[2];
        next_cur.src[`BIT_TXA] = next_cur.src[`BIT_TXA] | ev[3];
        next_cur.src[`BIT_FTX] = next_cur.src[`BIT_FTX] | ev[4];
        next_cur.src[`BIT_TBUSY] = 1'b0;

        next_cur.irq_n = !(next_cur.src[`BIT_INIT] || (cur.int_enable[`BIT_GIE] &&
            |(next_cur.src[6:1] & cur.int_enable[6:1])));
        next_cur.txd_oe = next_cur.tx_drive && !next_cur.src[`BIT_INIT];
        next_cur.txd = next_cur.tx_bit ^ cur.enh_cnt[0];
    end

    // ----------------------------------------------------------------------
    // Registers and buffers
    // ----------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cur <= '0;
            cur.rate_mode <= `RST_RATE_MODE;
            cur.int_enable <= `RST_INT_ENABLE;
            cur.src <= 7'h01;
            cur.irq_n <= 1'b0;
            cur.tx_st <= TX_IDLE;
            cur.rx_st <= RX_IDLE;
        end else begin
            cur <= next_cur;
        end
    end

    always_ff @(posedge hclk) begin
        if (cur.wr && cur.addr[7:6] == 2'b01 && !tx_busy) begin
            tx_buf[cur.addr[6:2]] <= hwdata[7:0];
        end
        if (cur.rx_st == RX_DATA && cur.bit_tick && cur.rx_bits == 3'd7 && !init_hold &&
            (cur.rx_match || cur.rx_idx < 5'd2)) begin
            rx_buf[cur.rx_sel][cur.rx_idx] <= {cur.rx_shift[6:0], rxd};
        end
    end

    assign hrdata = cur.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign txd = cur.txd;
    assign txd_oe = cur.txd_oe;
    assign irq_n = cur.irq_n;
endmodule

/* File: test/bus_node_model.sv */
/* Model of the other nodes on the shared serial wire.
   Assumes a pull-up holds the released wire high. */
`timescale 1ns/1ns
module bus_node_model (
    input wire logic txd,
    input wire logic txd_oe,
    input wire logic jam,
    output logic rxd
);
    logic level;
    // ------------------------------------------------------------
    // Wire level
    // ------------------------------------------------------------
    // Released wire rests at the pull-up level
    assign level = txd_oe ? txd : 1'b1;
    // A stronger node overdrives the wire on command
    assign rxd = jam ? ~level : level;
endmodule

/* File: test/frame_ctl_props.sv */
/* Port checker of the frame controller.
   Assumes binding to serial_bus_frame_controller, one clock domain. */
`timescale 1ns/1ns
module frame_ctl_props (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic rxd,
    input wire logic txd,
    input wire logic txd_oe,
    input wire logic irq_n
);
    logic dp_wr, init_p, armed, tx_q, seen, rd_tx;
    logic [7:0] dp_a, en, rate;
    logic [15:0] gap;
    int slot;
    // ------------------------------------------------------------
    // Shadow of host writes and wire timing
    // ------------------------------------------------------------
    assign slot = (rate[4] ? 48 : 16) << rate[2:0];
    assign rd_tx = hsel && hready && htrans[1] && !hwrite && haddr[7:6] == 2'b01;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr <= 1'b0;
            dp_a <= 8'h00;
            init_p <= 1'b1;
            armed <= 1'b0;
            en <= 8'h00;
            rate <= 8'h00;
            tx_q <= 1'b0;
            seen <= 1'b0;
            gap <= 16'h0000;
        end else begin
            dp_wr <= hsel && hready && htrans[1] && hwrite;
            dp_a <= (hsel && hready && htrans[1]) ? haddr : dp_a;
            tx_q <= txd;
            gap <= (txd_oe && txd == tx_q) ? gap + 16'h0001 : 16'h0000;
            seen <= txd_oe && (seen || txd != tx_q);
            if (dp_wr) begin
                case (dp_a)
                    8'h00: init_p <= init_p | hwdata[0];
                    8'h10: init_p <= init_p & ~hwdata[0];
                    8'h04: rate <= hwdata[7:0];
                    8'h0C: en <= hwdata[7:0];
                    8'h18: armed <= armed | (hwdata[7] && hwdata[4:0] >= 5'h02
                        && hwdata[4:0] <= 5'h1E);
                    default: ;
                endcase
            end
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_no_drive;
        init_p |-> !txd_oe;
    endproperty
    a_no_drive: assert property (p_no_drive) else $error("wire driven during init");
    property p_irq_init;
        init_p && $past(init_p) && $past(init_p, 2) |-> !irq_n;
    endproperty
    a_irq_init: assert property (p_irq_init) else $error("init not signalled");
    property p_irq_release;
        dp_wr && dp_a == 8'h10 && hwdata[0] && !en[7] |-> ##[1:3] irq_n;
    endproperty
    a_irq_release: assert property (p_irq_release) else $error("init not cleared");
    property p_irq_gdis;
        (!en[7] && !init_p) [*3] |-> irq_n;
    endproperty
    a_irq_gdis: assert property (p_irq_gdis) else $error("irq with global off");
    property p_rts;
        $rose(txd_oe) |-> armed;
    endproperty
    a_rts: assert property (p_rts) else $error("frame without valid request");
    property p_rate;
        txd_oe && seen && txd != tx_q |-> (int'(gap) + 1) % slot == 0;
    endproperty
    a_rate: assert property (p_rate) else $error("edge off slot grid");
    property p_collision;
        (txd_oe && rxd != txd) [*4] |-> ##[0:100] !txd_oe;
    endproperty
    a_collision: assert property (p_collision) else $error("drive after collision");
    property p_txbuf;
        (rd_tx && txd_oe) ##1 txd_oe |-> hrdata == 32'h00000000;
    endproperty
    a_txbuf: assert property (p_txbuf) else $error("busy buffer readable");
    c_tx: cover property ($rose(txd_oe));
    c_coll: cover property ((txd_oe && rxd != txd) [*4]);
    c_clear: cover property (dp_wr && dp_a == 8'h10 && hwdata[0]);
endmodule
bind serial_bus_frame_controller frame_ctl_props frame_ctl_props_inst (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .rxd(rxd), .txd(txd),
    .txd_oe(txd_oe), .irq_n(irq_n));

/* File: test/serial_bus_frame_controller_tb.sv */
/* Self-checking bench of the frame controller.
   Assumes the bound checker and the bus node model. */
`timescale 1ns/1ns
`define CHK(nm, e, g) begin \
    checks++; \
    if ((g) !== (e)) begin \
        n_errors++; \
        $display("mismatch %s expected %h seen %h", nm, e, g); \
    end \
end
module serial_bus_frame_controller_tb;
    import frame_ctl_pkg::*;
    logic hclk, hresetn, hsel, hwrite, jam, rd_now, hreadyout, hresp, rxd, txd, txd_oe, irq_n;
    wire logic hready;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rnd;
    logic [63:0] e;
    logic [15:0] cnt;
    logic [11:0] filter_id [16];
    logic [63:0] expq [$];
    int n_errors, checks, n;
    assign hready = hreadyout;
    serial_bus_frame_controller serial_bus_frame_controller_inst (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .filter_id(filter_id), .rxd(rxd),
        .txd(txd), .txd_oe(txd_oe), .irq_n(irq_n));
    bus_node_model bus_node_model_inst (.txd(txd), .txd_oe(txd_oe), .jam(jam), .rxd(rxd));
    // ------------------------------------------------------------
    // Clock, helpers and bus tasks
    // ------------------------------------------------------------
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic summarize();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic rdy();
        for (int k = 0; k < 16; k++) begin
            @(posedge hclk);
            if (hreadyout === 1'b1) return;
        end
        n_errors++;
        summarize();
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= a;
        rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        rd_now <= !w;
        rdy();
        rd_now <= 1'b0;
        @(posedge hclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
        expq.push_back({m, x & m});
        ahb(1'b0, a, 32'h00000000);
    endtask
    task automatic wait_oe(input logic v, input int lim);
        n = 0;
        while (txd_oe !== v && n < lim) begin
            @(posedge hclk);
            n++;
        end
        if (n == lim) begin
            n_errors++;
            summarize();
        end
    endtask
    // Watcher of read results
    always @(posedge hclk) begin
        if (rd_now === 1'b1 && expq.size() > 0) begin
            e = expq.pop_front();
            `CHK("hrdata", e[31:0], hrdata & e[63:32])
        end
    end
    initial begin
        #400000;
        n_errors++;
        summarize();
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        {hresetn, hsel, hwrite, jam, rd_now, haddr, htrans, hwdata} = '0;
        hsize = 3'h2;
        n_errors = 0;
        checks = 0;
        rnd = 32'h0001525B;
        for (int i = 0; i < 16; i++) begin
            rnd = xs(rnd);
            filter_id[i] = rnd[11:0];
        end
        repeat (5) @(posedge hclk);
        `CHK("irq_n", 1'b0, irq_n)
        `CHK("txd_oe", 1'b0, txd_oe)
        hresetn <= 1'b1;
        rd(8'h08, 32'h1, 32'h1);
        rd(8'h04, 32'h0, 32'hFF);
        rd(8'h3C, 32'h0, 32'hFFFFFFFF);
        rd(8'h1C, 32'h0, 32'h80);
        ahb(1'b1, 8'h10, 32'h0);
        rd(8'h08, 32'h1, 32'h1);
        ahb(1'b1, 8'h10, 32'h1);
        rd(8'h08, 32'h0, 32'h1);
        `CHK("irq_n", 1'b1, irq_n)
        ahb(1'b1, 8'h00, 32'h1);
        repeat (3) @(posedge hclk);
        `CHK("irq_n", 1'b0, irq_n)
        ahb(1'b1, 8'h0C, 32'h80);
        ahb(1'b1, 8'h10, 32'h1);
        repeat (3) @(posedge hclk);
        `CHK("irq_n", 1'b1, irq_n)
        for (int i = 0; i < 4; i++) begin
            rnd = xs(rnd);
            ahb(1'b1, 8'h04, {26'h0, rnd[5:0]});
            rd(8'h04, {26'h0, rnd[5:0]}, 32'h3F);
        end
        ahb(1'b1, 8'h04, 32'h0);
        ahb(1'b1, 8'h18, 32'h81);
        ahb(1'b1, 8'h18, 32'h9F);
        cnt = 16'h0000;
        repeat (600) begin
            @(posedge hclk);
            cnt = cnt + {15'h0, txd_oe};
        end
        `CHK("oe cycles", 16'h0000, cnt)
        rd(8'h14, 32'h80, 32'h80);
        for (int i = 0; i < 4; i++) begin
            rnd = xs(rnd);
            ahb(1'b1, 8'h40 + 8'(i * 4), {24'h0, rnd[7:0]});
        end
        ahb(1'b1, 8'h18, 32'h84);
        ahb(1'b1, 8'h10, 32'h20);
        wait_oe(1'b1, 3000);
        rd(8'h40, 32'h0, 32'hFF);
        wait_oe(1'b0, 20000);
        repeat (8) @(posedge hclk);
        rd(8'h08, 32'h20, 32'h20);
        rd(8'h14, 32'h80, 32'h80);
        ahb(1'b1, 8'h0C, 32'hA0);
        repeat (3) @(posedge hclk);
        `CHK("irq_n", 1'b0, irq_n)
        ahb(1'b1, 8'h10, 32'h20);
        repeat (3) @(posedge hclk);
        `CHK("irq_n", 1'b1, irq_n)
        ahb(1'b1, 8'h04, 32'h1);
        ahb(1'b1, 8'h18, 32'h84);
        wait_oe(1'b1, 6000);
        repeat (100) @(posedge hclk);
        jam <= 1'b1;
        wait_oe(1'b0, 100);
        jam <= 1'b0;
        wait_oe(1'b1, 10000);
        wait_oe(1'b0, 40000);
        summarize();
    end
endmodule
